/* pkg/eeprom_pkg.sv */
`default_nettype none
package eeprom_pkg;
   // system clock rate
   localparam int CLK_HZ = 25_000_000;
   // memory organisation
   localparam int MEM_BYTES = 128;
   localparam int ADDR_W = 7;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_W = 4;
   // slave address byte: fixed upper nibble, three ignored bits, direction
   localparam logic [3:0] SLAVE_PATTERN = 4'ha;
   localparam logic [2:0] SLAVE_FILL = 3'h0;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;
   // bit slots within one nine-clock byte frame
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // internal write cycle, longest time rounds down
   localparam int WRITE_CYCLE_MS = 5;
   localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * (CLK_HZ / 1000);
   // master bus clock, each bit split in four quarters
   localparam int SCL_KHZ = 100;
   localparam int QUARTER_CYC = CLK_HZ / (SCL_KHZ * 1000 * 4);
   // master write data buffer
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 32;
   // reset levels of the synchronisers: idle bus is high
   localparam logic [1:0] BUS_IDLE_SYNC = 2'h3;
   localparam logic [1:0] TOC_RESET_SYNC = 2'h0;
endpackage
`default_nettype wire

/* pkg/eeprom_link_if.sv */
`default_nettype none
interface eeprom_link_if;
   logic scl;
   logic transmit_only_clock;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic sda;
   // open-drain wired-and with pull-up: any enabled low driver wins
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
   modport device (
      input scl,
      input transmit_only_clock,
      input sda,
      output dev_sda_o,
      output dev_sda_oe_n
   );
   modport host (
      output scl,
      output transmit_only_clock,
      input sda,
      output host_sda_o,
      output host_sda_oe_n
   );
endinterface
`default_nettype wire

/* design/sync_fifo.sv */
`default_nettype none
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   // extra pointer bit tells full from empty
   logic [PW:0] wr_ptr_ff;
   logic [PW:0] rd_ptr_ff;
   logic push;
   logic pop;

   assign in_ready = (wr_ptr_ff[PW] == rd_ptr_ff[PW]) || (wr_ptr_ff[PW-1:0] != rd_ptr_ff[PW-1:0]);
   assign out_valid = wr_ptr_ff != rd_ptr_ff;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = store[rd_ptr_ff[PW-1:0]];

   // pointers
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         if (pop)
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
   end

   // storage has no reset, only the pointers matter
   always_ff @(posedge sys_clk)
   begin
      if (push)
         store[wr_ptr_ff[PW-1:0]] <= in_data;
   end
endmodule
`default_nettype wire

/* design/eeprom_device.sv */
// Function
// - no programming while transmit-only clock is low
// - started write cycle always runs to completion
// - byte write: address, byte address, data, stop
// - program at stop, ignore bus while busy
// - page write carries up to sixteen bytes
// - ack each data byte, bump low address bits
// - excess page bytes wrap and overwrite earlier ones
// - received page bytes programmed in one cycle
// - address ack withheld until programming finishes
// - grounded transmit-only clock makes memory read-only
// - read uses direction bit set to one
// - counter holds last address plus one, wraps
// - selective read: dummy write, restart, read byte
// - sequential read follows immediate or selective read
// - one byte per master ack, stop on nack
// - match upper nibble, ignore three bits, direction
// - data line released during internal write cycle
`default_nettype none
module eeprom_device
   import eeprom_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_CYCLE_CYC
) (
   input wire logic sys_clk,
   input wire logic rstn,
   eeprom_link_if.device link,
   output logic prog_busy,
   output logic protect_active
);
   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

   typedef enum logic [5:0] {
      st_idle  = 6'h01,
      st_slave = 6'h02,
      st_word  = 6'h04,
      st_data  = 6'h08,
      st_read  = 6'h10,
      st_prog  = 6'h20
   } dev_state_e;

   dev_state_e state_ff;
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic [1:0] toc_sync_ff;
   logic scl_prev_ff;
   logic sda_prev_ff;
   logic [3:0] bitcnt_ff;
   logic [7:0] rx_ff;
   logic [7:0] tx_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic drive_ff;
   logic mack_ff;
   logic wr_pend_ff;
   logic [PAGE_BYTES-1:0] valid_ff;
   logic [7:0] pbuf [PAGE_BYTES];
   logic [7:0] mem [MEM_BYTES];
   logic [CNT_W-1:0] prog_cnt_ff;

   logic scl_s;
   logic sda_s;
   logic toc_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic fall7;
   logic fall8;
   logic addr_match;
   logic dir_read;
   logic rx_state;
   logic load_tx;
   logic prog_last;
   logic [7:0] mem_out;

   // two flip-flops on every pin before any logic looks at it
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         scl_sync_ff <= BUS_IDLE_SYNC;
         sda_sync_ff <= BUS_IDLE_SYNC;
         toc_sync_ff <= TOC_RESET_SYNC;
      end
      else
      begin
         scl_sync_ff <= {scl_sync_ff[0], link.scl};
         sda_sync_ff <= {sda_sync_ff[0], link.sda};
         toc_sync_ff <= {toc_sync_ff[0], link.transmit_only_clock};
      end
   end

   assign scl_s = scl_sync_ff[1];
   assign sda_s = sda_sync_ff[1];
   assign toc_s = toc_sync_ff[1];

   // previous synchronised levels for edge finding
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end
      else
      begin
         scl_prev_ff <= scl_s;
         sda_prev_ff <= sda_s;
      end
   end

   // bus events; both lines share the same synchroniser delay
   assign scl_rise = scl_s & ~scl_prev_ff;
   assign scl_fall = ~scl_s & scl_prev_ff;
   assign start_det = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
   assign stop_det = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
   assign fall7 = scl_fall && (bitcnt_ff == LAST_DATA_BIT);
   assign fall8 = scl_fall && (bitcnt_ff == ACK_SLOT);
   assign addr_match = rx_ff[7:4] == SLAVE_PATTERN;
   assign dir_read = rx_ff[0] == DIR_READ;
   assign rx_state = (state_ff == st_slave) || (state_ff == st_word) || (state_ff == st_data);
   assign mem_out = mem[addr_ff];
   // next byte goes out after an address ack in read direction or a master ack
   assign load_tx = fall8 && (((state_ff == st_slave) && addr_match && dir_read)
                    || ((state_ff == st_read) && mack_ff));
   assign prog_last = prog_cnt_ff == CNT_W'(WRITE_CYCLES - 1);

   // protocol sequencer; the write cycle outranks every bus event
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         state_ff <= st_idle;
         bitcnt_ff <= 4'h0;
      end
      else if (state_ff == st_prog)
      begin
         if (prog_last)
            state_ff <= st_idle;
      end
      else if (start_det)
      begin
         state_ff <= st_slave;
         bitcnt_ff <= 4'hf; // first fall after start only opens the msb slot
      end
      else if (stop_det)
      begin
         // toc low at stop means nothing is programmed at all
         state_ff <= (wr_pend_ff && toc_s) ? st_prog : st_idle;
         bitcnt_ff <= 4'h0;
      end
      else if (scl_fall && (state_ff != st_idle))
      begin
         bitcnt_ff <= (bitcnt_ff == ACK_SLOT) ? 4'h0 : bitcnt_ff + 4'h1;
         if (fall8)
         begin
            if (state_ff == st_slave)
               state_ff <= !addr_match ? st_idle : (dir_read ? st_read : st_word);
            else if (state_ff == st_word)
               state_ff <= st_data;
            else if ((state_ff == st_read) && !mack_ff)
               state_ff <= st_idle;
         end
      end
   end

   // receive shift on rising clock, master ack sampled in the ninth slot
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         rx_ff <= 8'h00;
         mack_ff <= 1'b0;
      end
      else if (scl_rise)
      begin
         if (rx_state && (bitcnt_ff != ACK_SLOT))
            rx_ff <= {rx_ff[6:0], sda_s};
         if ((state_ff == st_read) && (bitcnt_ff == ACK_SLOT))
            mack_ff <= ~sda_s;
      end
   end

   // address counter: full wrap on reads, in-page wrap on writes
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         addr_ff <= '0;
      else if (fall7 && (state_ff == st_word))
         addr_ff <= rx_ff[ADDR_W-1:0];
      else if (fall7 && (state_ff == st_data))
         addr_ff[PAGE_W-1:0] <= addr_ff[PAGE_W-1:0] + 4'h1;
      else if (load_tx)
         addr_ff <= addr_ff + 7'h01;
   end

   // transmit byte, most significant bit first
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         tx_ff <= 8'h00;
      else if (load_tx)
         tx_ff <= mem_out;
      else if (scl_fall && (state_ff == st_read) && (bitcnt_ff < LAST_DATA_BIT))
         tx_ff <= {tx_ff[6:0], 1'b0};
   end

   // open-drain pull-down; released whenever the write cycle runs
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         drive_ff <= 1'b0;
      else if ((state_ff == st_prog) || start_det || stop_det)
         drive_ff <= 1'b0;
      else if (fall7)
         // ack own address, byte address and each data byte
         drive_ff <= ((state_ff == st_slave) && addr_match) || (state_ff == st_word)
                     || (state_ff == st_data);
      else if (fall8)
         drive_ff <= load_tx ? ~mem_out[7] : 1'b0;
      else if (scl_fall && (state_ff == st_read) && (bitcnt_ff < LAST_DATA_BIT))
         drive_ff <= ~tx_ff[6];
   end

   // pending write flag; a restart drops an unfinished write sequence
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         wr_pend_ff <= 1'b0;
      else if ((state_ff == st_prog) || start_det || stop_det)
         wr_pend_ff <= 1'b0;
      else if (fall7 && (state_ff == st_data))
         wr_pend_ff <= 1'b1;
   end

   // page buffer: later bytes to the same slot replace earlier ones
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         valid_ff <= '0;
      else if (fall7 && (state_ff == st_word))
         valid_ff <= '0;
      else if (fall7 && (state_ff == st_data))
         valid_ff[addr_ff[PAGE_W-1:0]] <= 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (fall7 && (state_ff == st_data))
         pbuf[addr_ff[PAGE_W-1:0]] <= rx_ff;
   end

   // write cycle timer, keeps running whatever the pins do
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         prog_cnt_ff <= '0;
      else if (state_ff != st_prog)
         prog_cnt_ff <= '0;
      else
         prog_cnt_ff <= prog_cnt_ff + 1'b1;
   end

   // commit all buffered bytes of the page at the end of the cycle
   always_ff @(posedge sys_clk)
   begin
      if ((state_ff == st_prog) && prog_last)
      begin
         for (int i = 0; i < PAGE_BYTES; i++)
         begin
            if (valid_ff[i])
               mem[{addr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf[i];
         end
      end
   end

   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe_n = ~drive_ff;
   assign prog_busy = state_ff == st_prog;
   assign protect_active = ~toc_s;
endmodule
`default_nettype wire

/* design/eeprom_host.sv */
`default_nettype none
module eeprom_host
   import eeprom_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYC,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rstn,
   eeprom_link_if.host link,
   input wire logic write_enable,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic cmd_addr_en,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [7:0] cmd_len,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic done,
   output logic nack
);
   localparam int QW = $clog2(QUARTER + 1);

   typedef enum logic [8:0] {
      h_idle   = 9'h001,
      h_start  = 9'h002,
      h_saddr  = 9'h004,
      h_word   = 9'h008,
      h_rstart = 9'h010,
      h_raddr  = 9'h020,
      h_wdata  = 9'h040,
      h_rdata  = 9'h080,
      h_stop   = 9'h100
   } host_state_e;

   host_state_e state_ff;
   logic [QW-1:0] qdiv_ff;
   logic [1:0] q_ff;
   logic [3:0] bit_ff;
   logic [1:0] sda_sync_ff;
   logic scl_ff;
   logic sda_low_ff;
   logic toc_ff;
   logic [7:0] tx_ff;
   logic [7:0] rx_ff;
   logic [7:0] cnt_ff;
   logic read_ff;
   logic addr_en_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic have_ff;
   logic rd_valid_ff;
   logic [7:0] rd_data_ff;
   logic done_ff;
   logic nack_ff;

   logic tick;
   logic stall;
   logic adv;
   logic op_end;
   logic byte_end;
   logic send_state;
   logic got_ack;
   logic fifo_valid;
   logic fifo_pop;
   logic [7:0] fifo_data;

   // write data waits here; the bus only drains it one byte per frame
   sync_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(DEPTH)
   ) wr_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // data line from the pin, two flip-flops
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         sda_sync_ff <= BUS_IDLE_SYNC;
      else
         sda_sync_ff <= {sda_sync_ff[0], link.sda};
   end

   // quarter-bit enable divider
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         qdiv_ff <= '0;
      else
         qdiv_ff <= tick ? '0 : qdiv_ff + 1'b1;
   end

   assign tick = qdiv_ff == QW'(QUARTER - 1);
   // an empty buffer stalls the clock instead of sending garbage
   assign stall = (state_ff == h_wdata) && !have_ff;
   assign adv = tick && !stall && (state_ff != h_idle);
   assign op_end = adv && (q_ff == 2'h3);
   assign byte_end = op_end && (bit_ff == ACK_SLOT);
   assign send_state = (state_ff == h_saddr) || (state_ff == h_word)
                       || (state_ff == h_raddr) || (state_ff == h_wdata);
   assign got_ack = ~sda_sync_ff[1];
   assign fifo_pop = stall && fifo_valid;

   // quarter phase and bit slot
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         q_ff <= 2'h0;
         bit_ff <= 4'h0;
      end
      else if (adv)
      begin
         q_ff <= q_ff + 2'h1;
         if (op_end)
            bit_ff <= (send_state || (state_ff == h_rdata)) && (bit_ff != ACK_SLOT)
                      ? bit_ff + 4'h1 : 4'h0;
      end
   end

   // clock low in quarters 1 and 2, high from quarter 3
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         scl_ff <= 1'b1;
      else if (adv && (q_ff == 2'h0))
         scl_ff <= 1'b0;
      else if (adv && (q_ff == 2'h2))
         scl_ff <= 1'b1;
   end

   // data only moves while the clock is low, except start and stop
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         sda_low_ff <= 1'b0;
      else if (adv && (q_ff == 2'h1))
      begin
         if ((state_ff == h_start) || (state_ff == h_rstart))
            sda_low_ff <= 1'b0;
         else if (state_ff == h_stop)
            sda_low_ff <= 1'b1;
         else if (send_state)
            sda_low_ff <= (bit_ff != ACK_SLOT) && !tx_ff[7];
         else if (state_ff == h_rdata)
            sda_low_ff <= (bit_ff == ACK_SLOT) && (cnt_ff > 8'h01);
      end
      else if (adv && (q_ff == 2'h3))
      begin
         if ((state_ff == h_start) || (state_ff == h_rstart))
            sda_low_ff <= 1'b1;
         else if (state_ff == h_stop)
            sda_low_ff <= 1'b0;
      end
   end

   // received bits sampled at the end of quarter 3, in the middle of the high phase
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         rx_ff <= 8'h00;
      else if (op_end && (state_ff == h_rdata) && (bit_ff != ACK_SLOT))
         rx_ff <= {rx_ff[6:0], sda_sync_ff[1]};
   end

   // transaction sequencer
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         state_ff <= h_idle;
         tx_ff <= 8'h00;
         cnt_ff <= 8'h00;
         read_ff <= 1'b0;
         addr_en_ff <= 1'b0;
         addr_ff <= '0;
         have_ff <= 1'b0;
         nack_ff <= 1'b0;
      end
      else if (state_ff == h_idle)
      begin
         if (cmd_valid)
         begin
            state_ff <= h_start;
            read_ff <= cmd_read;
            addr_en_ff <= cmd_addr_en;
            addr_ff <= cmd_addr;
            cnt_ff <= cmd_len;
            nack_ff <= 1'b0;
         end
      end
      else
      begin
         if (fifo_pop)
         begin
            tx_ff <= fifo_data;
            have_ff <= 1'b1;
         end
         if (op_end && send_state && (bit_ff != ACK_SLOT))
            tx_ff <= {tx_ff[6:0], 1'b0};
         if (op_end && (state_ff == h_start))
         begin
            state_ff <= h_saddr;
            tx_ff <= {SLAVE_PATTERN, SLAVE_FILL, read_ff && !addr_en_ff};
         end
         if (op_end && (state_ff == h_rstart))
         begin
            state_ff <= h_raddr;
            tx_ff <= {SLAVE_PATTERN, SLAVE_FILL, DIR_READ};
         end
         if (op_end && (state_ff == h_stop))
            state_ff <= h_idle;
         if (byte_end && (state_ff != h_rdata) && !got_ack)
         begin
            // a busy device withholds its ack: report and stop
            state_ff <= h_stop;
            nack_ff <= 1'b1;
            have_ff <= 1'b0; // a refused byte is dropped, never sent by a later command
         end
         else if (byte_end)
         begin
            unique case (state_ff)
               h_saddr:
               begin
                  if (addr_en_ff)
                  begin
                     state_ff <= h_word;
                     tx_ff <= {1'b0, addr_ff};
                  end
                  else if (read_ff)
                     state_ff <= h_rdata;
                  else
                     state_ff <= (cnt_ff == 8'h00) ? h_stop : h_wdata;
               end
               h_word:
               begin
                  if (read_ff)
                     state_ff <= h_rstart;
                  else
                     state_ff <= (cnt_ff == 8'h00) ? h_stop : h_wdata;
               end
               h_raddr:
                  state_ff <= h_rdata;
               h_wdata:
               begin
                  have_ff <= 1'b0;
                  cnt_ff <= cnt_ff - 8'h01;
                  if (cnt_ff <= 8'h01)
                     state_ff <= h_stop;
               end
               h_rdata:
               begin
                  cnt_ff <= cnt_ff - 8'h01;
                  if (cnt_ff <= 8'h01)
                     state_ff <= h_stop;
               end
               default:
                  state_ff <= h_stop;
            endcase
         end
      end
   end

   // result pulses and write-enable level
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         rd_valid_ff <= 1'b0;
         rd_data_ff <= 8'h00;
         done_ff <= 1'b0;
         toc_ff <= 1'b0;
      end
      else
      begin
         rd_valid_ff <= byte_end && (state_ff == h_rdata);
         if (byte_end && (state_ff == h_rdata))
            rd_data_ff <= rx_ff;
         done_ff <= op_end && (state_ff == h_stop);
         toc_ff <= write_enable;
      end
   end

   assign cmd_ready = state_ff == h_idle;
   assign rd_valid = rd_valid_ff;
   assign rd_data = rd_data_ff;
   assign done = done_ff;
   assign nack = nack_ff;
   assign link.scl = scl_ff;
   assign link.transmit_only_clock = toc_ff;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe_n = ~sda_low_ff;
endmodule
`default_nettype wire

/* test/eeprom_link_chk.sv */
`default_nettype none
module eeprom_link_chk #(
   parameter int WRITE_CYCLES = 1000
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic scl,
   input wire logic transmit_only_clock,
   input wire logic sda,
   input wire logic dev_sda_oe_n,
   input wire logic prog_busy,
   input wire logic protect_active
);
   timeunit 1ns;
   timeprecision 1ps;
   int busy_cnt_ff;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // cycles spent in the current write cycle; holds the total for one cycle after it, then zero
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || !prog_busy)
         busy_cnt_ff <= 0;
      else
         busy_cnt_ff <= busy_cnt_ff + 1;
   end
   property p_busy_rel; prog_busy |-> dev_sda_oe_n; endproperty
   a_busy_rel: assert property (p_busy_rel) else $error("sda driven in write cycle");
   property p_busy_len; $fell(prog_busy) |-> busy_cnt_ff == WRITE_CYCLES; endproperty
   a_busy_len: assert property (p_busy_len) else $error("write cycle length off");
   property p_prot; $rose(prog_busy) |-> !protect_active; endproperty
   a_prot: assert property (p_prot) else $error("programming while protected");
   // a dropped enable must not cut a running cycle short
   property p_keep; prog_busy && !transmit_only_clock |=>
      prog_busy || busy_cnt_ff == WRITE_CYCLES; endproperty
   a_keep: assert property (p_keep) else $error("write cycle aborted");
   property p_toc; $fell(transmit_only_clock) |-> ##[1:4] protect_active; endproperty
   a_toc: assert property (p_toc) else $error("protection not raised");
   property p_stop; $rose(prog_busy) |-> scl && sda; endproperty
   a_stop: assert property (p_stop) else $error("write cycle not after stop");
   property p_drv_low; $fell(dev_sda_oe_n) |-> !scl; endproperty
   a_drv_low: assert property (p_drv_low) else $error("device drove with scl high");
   property p_ack_hold; $fell(dev_sda_oe_n) |=> !dev_sda_oe_n [*4]; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("device drive too short");
endmodule
`default_nettype wire

/* test/tb_top.sv */
`default_nettype none
module tb_top import eeprom_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WCYC = 1000;
   logic sys_clk, rstn, write_enable, cmd_valid, cmd_read, cmd_addr_en, wr_valid;
   logic [6:0] cmd_addr;
   logic [7:0] cmd_len, wr_data, rd_data;
   logic cmd_ready, wr_ready, rd_valid, done, nack, prog_busy, protect_active;
   logic [7:0] exp_mem [MEM_BYTES];
   logic [7:0] rq [$];
   int bad_count, n_checks, cyc_ff, i;
   eeprom_link_if link();
   eeprom_host #(.QUARTER(8), .DEPTH(FIFO_DEPTH)) eeprom_host_inst (.sys_clk(sys_clk),
      .rstn(rstn), .link(link), .write_enable(write_enable), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr_en(cmd_addr_en),
      .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
   eeprom_device #(.WRITE_CYCLES(WCYC)) eeprom_device_inst (.sys_clk(sys_clk), .rstn(rstn),
      .link(link), .prog_busy(prog_busy), .protect_active(protect_active));
   eeprom_link_chk #(.WRITE_CYCLES(WCYC)) eeprom_link_chk_inst (.sys_clk(sys_clk),
      .rstn(rstn), .scl(link.scl), .transmit_only_clock(link.transmit_only_clock),
      .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n), .prog_busy(prog_busy),
      .protect_active(protect_active));
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // strobe stays up between pushes so no edge sees it dropped and raised
   task automatic push(input logic [7:0] d);
      wr_data <= d;
      wr_valid <= 1'b1;
      @(posedge sys_clk);
      while (wr_ready !== 1'b1)
         @(posedge sys_clk);
   endtask
   task automatic cmd(input logic r, input logic ae, input logic [6:0] a, input logic [7:0] n);
      int t;
      rq.delete();
      cmd_read <= r;
      cmd_addr_en <= ae;
      cmd_addr <= a;
      cmd_len <= n;
      cmd_valid <= 1'b1;
      @(posedge sys_clk);
      while (cmd_ready !== 1'b1)
         @(posedge sys_clk);
      cmd_valid <= 1'b0;
      for (t = 0; t < 10000; t++)
      begin
         @(posedge sys_clk);
         if (rd_valid === 1'b1)
            rq.push_back(rd_data);
         if (done === 1'b1)
            break;
      end
      chk(8'(t < 10000), 8'h01);
   endtask
   // first poll shows whether a write cycle really started
   task automatic poll(input logic busy);
      int k;
      cmd(1'b0, 1'b0, 7'h00, 8'h00);
      chk(8'(nack), 8'(busy));
      for (k = 0; k < 40 && nack !== 1'b0; k++)
         cmd(1'b0, 1'b0, 7'h00, 8'h00);
      chk(8'(nack), 8'h00);
   endtask
   task automatic rdchk(input logic ae, input logic [6:0] a, input logic [7:0] n);
      int j;
      cmd(1'b1, ae, a, n);
      chk(8'(rq.size()), n);
      for (j = 0; j < rq.size(); j++)
         chk(rq[j], exp_mem[(int'(a) + j) % MEM_BYTES]);
   endtask
   // hang guard, well above the expected run length
   always @(posedge sys_clk)
   begin
      cyc_ff <= cyc_ff + 1;
      if (cyc_ff == 60000)
      begin
         bad_count++;
         results();
      end
   end
   initial
   begin
      cyc_ff = 0;
      rstn = 1'b0;
      write_enable = 1'b1;
      cmd_valid = 1'b0;
      cmd_read = 1'b0;
      cmd_addr_en = 1'b0;
      cmd_addr = 7'h00;
      cmd_len = 8'h00;
      wr_valid = 1'b0;
      wr_data = 8'h00;
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      // byte write, enable dropped while it programs
      exp_mem[0] = 8'h3c;
      push(8'h3c);
      wr_valid <= 1'b0;
      cmd(1'b0, 1'b1, 7'h00, 8'h01);
      write_enable <= 1'b0;
      poll(1'b1);
      write_enable <= 1'b1;
      rdchk(1'b1, 7'h00, 8'h01);
      // fill the buffer until it refuses
      for (i = 0; i < FIFO_DEPTH; i++)
         push(8'h40 + 8'(i));
      wr_valid <= 1'b0;
      @(posedge sys_clk);
      chk(8'(wr_ready), 8'h00);
      for (i = 0; i < 18; i++)
         exp_mem[16 + (14 + i) % PAGE_BYTES] = 8'h40 + 8'(i);
      for (i = 0; i < 14; i++)
         exp_mem[112 + (14 + i) % PAGE_BYTES] = 8'h52 + 8'(i);
      cmd(1'b0, 1'b1, 7'h1e, 8'h12);
      poll(1'b1);
      cmd(1'b0, 1'b1, 7'h7e, 8'h0e);
      poll(1'b1);
      rdchk(1'b1, 7'h10, 8'h10);
      rdchk(1'b1, 7'h7e, 8'h01);
      rdchk(1'b0, 7'h7f, 8'h02);
      // protected write must leave memory alone
      write_enable <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(8'(protect_active), 8'h01);
      push(8'hff);
      wr_valid <= 1'b0;
      cmd(1'b0, 1'b1, 7'h00, 8'h01);
      poll(1'b0);
      chk(8'(prog_busy), 8'h00);
      rdchk(1'b1, 7'h00, 8'h01);
      chk(8'(link.sda & link.scl), 8'h01);
      results();
   end
endmodule
`default_nettype wire
